/* common/acs_pkg.sv */
package acs_pkg;

	// Register byte offsets on the AXI4-Lite slave
	localparam logic [7:0] OFS_CONTROL_A = 8'h00;
	localparam logic [7:0] OFS_CONTROL_B = 8'h04;
	localparam logic [7:0] OFS_TRIGGER = 8'h08;
	localparam logic [7:0] OFS_RESULT_HIGH = 8'h0c;
	localparam logic [7:0] OFS_RESULT_LOW = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;

	// Field positions in converter_control_a
	localparam int CA_ENABLE = 0;
	localparam int CA_GO = 1;
	localparam int CA_CHAN_LO = 2;
	// Field positions in converter_control_b
	localparam int CB_PREF_LO = 0;
	localparam int CB_NREF = 2;
	localparam int CB_CKS_LO = 4;
	localparam int CB_JUSTIFY = 7;
	// Field positions in status
	localparam int ST_DONE = 0;
	localparam int ST_IRQ_EN = 1;
	localparam int ST_POWERED = 2;

	// Conversion clock select codes
	localparam logic [2:0] CKS_DIV2 = 3'h0;
	localparam logic [2:0] CKS_DIV4 = 3'h4;
	localparam logic [2:0] CKS_DIV8 = 3'h1;
	localparam logic [2:0] CKS_DIV16 = 3'h5;
	localparam logic [2:0] CKS_DIV32 = 3'h2;
	localparam logic [2:0] CKS_DIV64 = 3'h6;
	localparam logic [1:0] CKS_RC_LOW = 2'h3;

	// Trigger select codes
	localparam logic [3:0] TRG_NONE = 4'h0;
	localparam logic [3:0] TRG_TIMER_ZERO = 4'h3;
	localparam logic [3:0] TRG_TIMER_ONE = 4'h4;
	localparam logic [3:0] TRG_TIMER_TWO = 4'h5;
	localparam logic [3:0] TRG_COMP_ONE = 4'h6;
	localparam logic [3:0] TRG_COMP_TWO = 4'h7;
	localparam logic [3:0] TRG_CELL_ONE = 4'h8;
	localparam logic [3:0] TRG_CELL_TWO = 4'h9;
	localparam logic [3:0] TRG_CAP_ONE = 4'hc;
	localparam logic [3:0] TRG_CAP_TWO = 4'hd;
	localparam int TRG_SOURCES = 9;

	// Conversion timing
	localparam int RES_BITS = 10;
	localparam logic [3:0] TAD_LAST = 4'hb;
	localparam logic [3:0] TAD_FIRST_BIT = 4'h1;
	localparam logic [2:0] INSTR_CLKS = 3'h4;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_DELAY = 2'b01,
		ST_CONV = 2'b10
	} acs_state_t;

endpackage

/* verilog/acs_trig_sync.sv */
`timescale 1ns/1ns
module acs_trig_sync (
	input wire logic clk, // System clock
	input wire logic reset_n, // Async reset
	input wire logic [8:0] src, // Raw trigger sources
	input wire logic [3:0] sel, // trigger_select code
	output logic pulse // One-cycle rising edge of selected source
);
	typedef struct packed {
		logic [8:0] meta;
		logic [8:0] sync;
		logic [8:0] prev;
		logic pulse;
	} acs_trig_t;

	acs_trig_t s_q;
	acs_trig_t s_d;
	logic [8:0] rise;

	always_comb begin
		s_d = s_q;
		s_d.meta = src;
		s_d.sync = s_q.meta;
		s_d.prev = s_q.sync;
		rise = s_q.sync & ~s_q.prev;
		unique case (sel)
			acs_pkg::TRG_TIMER_ZERO: s_d.pulse = rise[0];
			acs_pkg::TRG_TIMER_ONE: s_d.pulse = rise[1];
			acs_pkg::TRG_TIMER_TWO: s_d.pulse = rise[2];
			acs_pkg::TRG_COMP_ONE: s_d.pulse = rise[3];
			acs_pkg::TRG_COMP_TWO: s_d.pulse = rise[4];
			acs_pkg::TRG_CELL_ONE: s_d.pulse = rise[5];
			acs_pkg::TRG_CELL_TWO: s_d.pulse = rise[6];
			acs_pkg::TRG_CAP_ONE: s_d.pulse = rise[7];
			acs_pkg::TRG_CAP_TWO: s_d.pulse = rise[8];
			// None and reserved codes never trigger
			default: s_d.pulse = 1'b0;
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign pulse = s_q.pulse;
endmodule // acs_trig_sync

/* verilog/acs_tad_gen.sv */
`timescale 1ns/1ns
module acs_tad_gen (
	input wire logic clk, // System clock
	input wire logic reset_n, // Async reset
	input wire logic run, // Count while converting
	input wire logic [2:0] cks, // conversion_clock_select
	input wire logic rc_tick, // dedicated_rc_clock period pulse
	output logic tick // One-cycle end of a bit_conversion_period
);
	typedef struct packed {
		logic [5:0] cnt;
		logic tick;
	} acs_tad_t;

	acs_tad_t s_q;
	acs_tad_t s_d;

	// Last count value of a divided period
	function automatic logic [5:0] div_last(input logic [2:0] code);
		unique case (code)
			acs_pkg::CKS_DIV2: return 6'h01;
			acs_pkg::CKS_DIV4: return 6'h03;
			acs_pkg::CKS_DIV8: return 6'h07;
			acs_pkg::CKS_DIV16: return 6'h0f;
			acs_pkg::CKS_DIV32: return 6'h1f;
			acs_pkg::CKS_DIV64: return 6'h3f;
			default: return 6'h01;
		endcase
	endfunction

	always_comb begin
		s_d = s_q;
		s_d.tick = 1'b0;
		if (!run) begin
			// Preload one: the registered tick costs a clock per conversion
			s_d.cnt = 6'h01;
		end else if (cks[1:0] == acs_pkg::CKS_RC_LOW) begin
			s_d.tick = rc_tick;
		end else if (s_q.cnt == div_last(cks)) begin
			s_d.cnt = 6'h00;
			s_d.tick = 1'b1;
		end else begin
			s_d.cnt = s_q.cnt + 6'h01;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign tick = s_q.tick;
endmodule // acs_tad_gen

/* verilog/acs_top.sv */
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////
module acs_top (
	input wire logic clk, // System clock, 20 MHz
	input wire logic reset_n, // Async reset, active low
	input wire logic [7:0] s_axi_awaddr, // Write address
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Write strobes
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [7:0] s_axi_araddr, // Read address
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [31:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read valid
	input wire logic s_axi_rready, // Read ready
	input wire logic sleep_mode, // Device is in Sleep
	input wire logic rc_tick, // dedicated_rc_clock period pulse
	input wire logic compare_high, // Input at or above sar_code
	input wire logic timer_zero_ovf, // timer_zero overflow
	input wire logic timer_one_ovf, // timer_one overflow
	input wire logic timer_two_match, // timer_two / timer_two_period match
	input wire logic comparator_one, // comparator_one output
	input wire logic comparator_two, // comparator_two output
	input wire logic logic_cell_one, // logic_cell_one output
	input wire logic logic_cell_two, // logic_cell_two output
	input wire logic capture_unit_one, // capture_unit_one output
	input wire logic capture_unit_two, // capture_unit_two output
	output logic [5:0] channel_select, // Analog channel to sample
	output logic [1:0] ref_pos_select, // Positive reference select
	output logic ref_neg_select, // Negative reference select
	output logic converter_powered, // Analog converter powered
	output logic sample_hold, // High while holding and converting
	output logic [9:0] sar_code, // Trial code to the comparator
	output logic wake_request // Wake-up request in Sleep
);
	typedef struct packed {
		acs_pkg::acs_state_t st;
		logic [2:0] dly;
		logic [3:0] tad;
		logic [9:0] acc;
		logic en;
		logic go;
		logic [5:0] chan;
		logic just;
		logic [2:0] cks;
		logic nref;
		logic [1:0] pref;
		logic [3:0] trig;
		logic [7:0] res_hi;
		logic [7:0] res_lo;
		logic done;
		logic irq_en;
		logic off;
		logic aw_ok;
		logic w_ok;
		logic [7:0] aw_addr;
		logic [7:0] w_data;
		logic w_lane;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [7:0] rdata;
		logic [1:0] rresp;
	} acs_regs_t;

	acs_regs_t s_q;
	acs_regs_t s_d;
	logic trig_pulse;
	logic tad_tick;
	logic rc_sel;
	logic wr_fire;
	logic start_req;
	logic abort_req;
	logic [9:0] partial;

	//////////////////////////////////////////////////////////////////////////////
	// Result packing and partial fill

	function automatic logic [15:0] pack_result(input logic [9:0] r, input logic right);
		if (right)
			return {6'h00, r};
		return {r, 6'h00};
	endfunction

	function automatic logic [9:0] fill_partial(input logic [9:0] a, input logic [3:0] t);
		logic [9:0] r;
		int last;
		r = a;
		last = acs_pkg::RES_BITS - int'(t) + 1;
		if (t <= acs_pkg::TAD_FIRST_BIT) begin
			r = 10'h000;
		end else if (t < acs_pkg::TAD_LAST) begin
			for (int i = 0; i < acs_pkg::RES_BITS; i++) begin
				if (i < last)
					r[i] = a[last];
			end
		end
		return r;
	endfunction

	//////////////////////////////////////////////////////////////////////////////
	// Helpers

	acs_trig_sync u_trig (
		.clk(clk),
		.reset_n(reset_n),
		.src({capture_unit_two, capture_unit_one, logic_cell_two, logic_cell_one,
			comparator_two, comparator_one, timer_two_match, timer_one_ovf,
			timer_zero_ovf}),
		.sel(s_q.trig),
		.pulse(trig_pulse)
	);

	acs_tad_gen u_tad (
		.clk(clk),
		.reset_n(reset_n),
		.run(s_q.st == acs_pkg::ST_CONV),
		.cks(s_q.cks),
		.rc_tick(rc_tick),
		.tick(tad_tick)
	);

	assign rc_sel = (s_q.cks[1:0] == acs_pkg::CKS_RC_LOW);
	assign wr_fire = s_q.aw_ok && s_q.w_ok && !s_q.bvalid;
	assign partial = fill_partial(s_q.acc, s_q.tad);

	//////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		s_d = s_q;
		start_req = 1'b0;
		abort_req = 1'b0;

		// Bus channel acceptance
		if (s_axi_awvalid && s_axi_awready) begin
			s_d.aw_ok = 1'b1;
			s_d.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			s_d.w_ok = 1'b1;
			s_d.w_data = s_axi_wdata[7:0];
			s_d.w_lane = s_axi_wstrb[0];
		end
		if (s_q.bvalid && s_axi_bready)
			s_d.bvalid = 1'b0;

		if (wr_fire) begin
			s_d.aw_ok = 1'b0;
			s_d.w_ok = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp = acs_pkg::RESP_OKAY;
			unique case (s_q.aw_addr)
				acs_pkg::OFS_CONTROL_A: if (s_q.w_lane) begin
					s_d.en = s_q.w_data[acs_pkg::CA_ENABLE];
					s_d.chan = s_q.w_data[acs_pkg::CA_CHAN_LO +: 6];
					if (s_q.w_data[acs_pkg::CA_GO])
						start_req = s_q.en && s_q.w_data[acs_pkg::CA_ENABLE];
					else
						abort_req = s_q.go;
				end
				acs_pkg::OFS_CONTROL_B: if (s_q.w_lane) begin
					s_d.just = s_q.w_data[acs_pkg::CB_JUSTIFY];
					s_d.cks = s_q.w_data[acs_pkg::CB_CKS_LO +: 3];
					s_d.nref = s_q.w_data[acs_pkg::CB_NREF];
					s_d.pref = s_q.w_data[acs_pkg::CB_PREF_LO +: 2];
				end
				acs_pkg::OFS_TRIGGER: if (s_q.w_lane)
					s_d.trig = s_q.w_data[3:0];
				acs_pkg::OFS_RESULT_HIGH: if (s_q.w_lane)
					s_d.res_hi = s_q.w_data;
				acs_pkg::OFS_RESULT_LOW: if (s_q.w_lane)
					s_d.res_lo = s_q.w_data;
				acs_pkg::OFS_STATUS: if (s_q.w_lane) begin
					s_d.irq_en = s_q.w_data[acs_pkg::ST_IRQ_EN];
					// Write one to clear; a new completion below wins
					if (s_q.w_data[acs_pkg::ST_DONE])
						s_d.done = 1'b0;
				end
				default: s_d.bresp = acs_pkg::RESP_SLVERR;
			endcase
		end

		if (trig_pulse && !sleep_mode && s_q.en)
			start_req = 1'b1;

		if (s_q.rvalid && s_axi_rready)
			s_d.rvalid = 1'b0;
		if (s_axi_arvalid && s_axi_arready) begin
			s_d.rvalid = 1'b1;
			s_d.rresp = acs_pkg::RESP_OKAY;
			unique case (s_axi_araddr)
				acs_pkg::OFS_CONTROL_A: s_d.rdata = {s_q.chan, s_q.go, s_q.en};
				acs_pkg::OFS_CONTROL_B:
					s_d.rdata = {s_q.just, s_q.cks, 1'b0, s_q.nref, s_q.pref};
				acs_pkg::OFS_TRIGGER: s_d.rdata = {4'h0, s_q.trig};
				acs_pkg::OFS_RESULT_HIGH: s_d.rdata = s_q.res_hi;
				acs_pkg::OFS_RESULT_LOW: s_d.rdata = s_q.res_lo;
				acs_pkg::OFS_STATUS:
					s_d.rdata = {5'h00, converter_powered, s_q.irq_en, s_q.done};
				default: begin
					s_d.rdata = 8'h00;
					s_d.rresp = acs_pkg::RESP_SLVERR;
				end
			endcase
		end

		// Sleep without RC clock powers down
		if (sleep_mode && !rc_sel)
			s_d.off = 1'b1;
		else if (!sleep_mode)
			s_d.off = 1'b0;

		// Conversion sequencer
		unique case (s_q.st)
			acs_pkg::ST_IDLE: begin
				if (start_req && !s_q.off && !(sleep_mode && !rc_sel)) begin
					s_d.go = 1'b1;
					s_d.acc = 10'h000;
					s_d.tad = 4'h0;
					if (rc_sel) begin
						s_d.st = acs_pkg::ST_DELAY;
						s_d.dly = acs_pkg::INSTR_CLKS - 3'h1;
					end else begin
						s_d.st = acs_pkg::ST_CONV;
					end
				end
			end
			acs_pkg::ST_DELAY: begin
				if (s_q.dly == 3'h0)
					s_d.st = acs_pkg::ST_CONV;
				else
					s_d.dly = s_q.dly - 3'h1;
			end
			acs_pkg::ST_CONV: begin
				if (tad_tick) begin
					if (s_q.tad == acs_pkg::TAD_LAST) begin
						s_d.st = acs_pkg::ST_IDLE;
						s_d.go = 1'b0;
						s_d.done = 1'b1;
						{s_d.res_hi, s_d.res_lo} = pack_result(s_q.acc, s_q.just);
						if (sleep_mode && !s_q.irq_en)
							s_d.off = 1'b1;
					end else begin
						if (s_q.tad >= acs_pkg::TAD_FIRST_BIT)
							s_d.acc[4'(acs_pkg::RES_BITS) - s_q.tad] = compare_high;
						s_d.tad = s_q.tad + 4'h1;
					end
				end
			end
			default: s_d.st = acs_pkg::ST_IDLE;
		endcase

		if (s_q.st != acs_pkg::ST_IDLE) begin
			if (!s_q.en || (wr_fire && !s_d.en) || (sleep_mode && !rc_sel)) begin
				s_d.st = acs_pkg::ST_IDLE;
				s_d.go = 1'b0;
			end else if (abort_req) begin
				s_d.st = acs_pkg::ST_IDLE;
				s_d.go = 1'b0;
				{s_d.res_hi, s_d.res_lo} = pack_result(partial, s_q.just);
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	//////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign s_axi_awready = !s_q.aw_ok && !s_q.bvalid;
	assign s_axi_wready = !s_q.w_ok && !s_q.bvalid;
	assign s_axi_bvalid = s_q.bvalid;
	assign s_axi_bresp = s_q.bresp;
	assign s_axi_arready = !s_q.rvalid;
	assign s_axi_rvalid = s_q.rvalid;
	assign s_axi_rdata = {24'h000000, s_q.rdata};
	assign s_axi_rresp = s_q.rresp;

	assign channel_select = s_q.chan;
	assign ref_pos_select = s_q.pref;
	assign ref_neg_select = s_q.nref;
	assign converter_powered = s_q.en && !s_q.off;
	assign sample_hold = (s_q.st == acs_pkg::ST_CONV);
	assign sar_code = s_q.acc;
	assign wake_request = sleep_mode && s_q.done && s_q.irq_en;
endmodule // acs_top

/* dv/acs_sva.sv */
`timescale 1ns/1ns
module acs_sva (
	input wire logic clk, // Clock
	input wire logic reset_n, // Reset
	input wire logic [7:0] s_axi_awaddr, // Write address
	input wire logic s_axi_awvalid, // Address valid
	input wire logic s_axi_awready, // Address ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic s_axi_wvalid, // Data valid
	input wire logic s_axi_wready, // Data ready
	input wire logic s_axi_bvalid, // Response valid
	input wire logic sleep_mode, // Sleep
	input wire logic converter_powered, // Powered
	input wire logic sample_hold, // Converting
	input wire logic wake_request // Wake
);
	logic take, pend_q, en_q, rc;
	logic [7:0] a_q, d_q;
	logic [2:0] cks_q;
	logic [9:0] hold_q;
	assign take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	assign rc = cks_q[1:0] == acs_pkg::CKS_RC_LOW;
	// Shadow fields commit one edge after the take, like the slave
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pend_q <= 1'h0;
			en_q <= 1'h0;
			a_q <= 8'h0;
			d_q <= 8'h0;
			cks_q <= 3'h0;
			hold_q <= 10'h0;
		end else begin
			pend_q <= take;
			a_q <= take ? s_axi_awaddr : a_q;
			d_q <= take ? s_axi_wdata[7:0] : d_q;
			if (pend_q && a_q == acs_pkg::OFS_CONTROL_A) begin
				en_q <= d_q[acs_pkg::CA_ENABLE];
			end
			if (pend_q && a_q == acs_pkg::OFS_CONTROL_B) begin
				cks_q <= d_q[6:4];
			end
			hold_q <= sample_hold ? hold_q + 10'h1 : 10'h0;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	AST_OFF_IDLE: assert property (!en_q [*2] |-> !sample_hold)
		else $error("conversion while disabled");
	AST_OFF_POWER: assert property (!en_q [*2] |-> !converter_powered)
		else $error("powered while disabled");
	AST_SLEEP_ABORT: assert property ((sleep_mode && !rc) [*3] |->
		!sample_hold && !converter_powered)
		else $error("sleep did not abort");
	AST_UNPOWERED_IDLE: assert property (!converter_powered |-> !sample_hold)
		else $error("converting while unpowered");
	AST_WAKE_SLEEP: assert property (wake_request |-> sleep_mode)
		else $error("wake outside sleep");
	// A status write lands one edge after its take, so look two back
	AST_WAKE_LEVEL: assert property (wake_request ##1 (sleep_mode && !s_axi_awvalid
		&& !$past(s_axi_awvalid) && !$past(s_axi_awvalid, 2)) |-> wake_request)
		else $error("wake dropped");
	AST_CONV_MAX: assert property (!rc |-> hold_q <= 10'd768)
		else $error("conversion too long");
	AST_B_RESP: assert property (take |-> ##2 s_axi_bvalid)
		else $error("no write response");
	cover property ($fell(sample_hold));
	cover property (wake_request);
	cover property (sleep_mode && en_q && !converter_powered);
endmodule // acs_sva
bind acs_top acs_sva u_sva (.clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .sleep_mode,
	.converter_powered, .sample_hold, .wake_request);

/* dv/acs_far.sv */
`timescale 1ns/1ns
module acs_far (
	input wire logic clk, // System clock
	input wire logic reset_n, // Async reset
	input wire logic vin, // Input at full scale
	input wire logic [8:0] kick, // One-cycle fire per source
	output logic compare_high, // Comparator answer
	output logic rc_tick, // RC period pulse
	output logic [8:0] src // Trigger levels
);
	logic [8:0] s1_q, s2_q, s3_q;
	logic [2:0] rc_q;
	// level held three clocks so it survives the synchroniser
	assign src = s1_q | s2_q | s3_q;
	// dedicated clock free runs, five clocks a period
	assign rc_tick = rc_q == 3'h4;
	// Ground or full scale, so every trial bit answers alike
	assign compare_high = vin;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s1_q <= 9'h0;
			s2_q <= 9'h0;
			s3_q <= 9'h0;
			rc_q <= 3'h0;
		end else begin
			s1_q <= kick;
			s2_q <= s1_q;
			s3_q <= s2_q;
			rc_q <= rc_tick ? 3'h0 : rc_q + 3'h1;
		end
	end
endmodule // acs_far

/* dv/tb.sv */
`timescale 1ns/1ns
module tb;
	localparam logic [7:0] CA = acs_pkg::OFS_CONTROL_A;
	localparam logic [7:0] CB = acs_pkg::OFS_CONTROL_B;
	localparam logic [7:0] RH = acs_pkg::OFS_RESULT_HIGH;
	localparam logic [7:0] RL = acs_pkg::OFS_RESULT_LOW;
	localparam logic [7:0] ST = acs_pkg::OFS_STATUS;
	localparam logic [1:0] OK = acs_pkg::RESP_OKAY;
	logic clk = 1'h0, reset_n = 1'h0, sleep_mode = 1'h0, vin = 1'h0;
	logic awvalid = 1'h0, wvalid = 1'h0, arvalid = 1'h0, bready = 1'h1, rready = 1'h1;
	logic [7:0] awaddr = 8'h0, araddr = 8'h0;
	logic [31:0] wdata = 32'h0, rdata;
	logic [8:0] kick = 9'h0, src;
	logic awready, wready, bvalid, arready, rvalid, pwr, hold, wake, cmp, rct, nref;
	logic [1:0] bresp, rresp, pref;
	logic [5:0] chan;
	logic [9:0] sar;
	logic [33:0] rq[$];
	logic [1:0] wq[$];
	int mismatches = 0, checks_done = 0;
	acs_top dut (.clk(clk), .reset_n(reset_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.sleep_mode(sleep_mode), .rc_tick(rct), .compare_high(cmp), .timer_zero_ovf(src[0]),
		.timer_one_ovf(src[1]), .timer_two_match(src[2]), .comparator_one(src[3]),
		.comparator_two(src[4]), .logic_cell_one(src[5]), .logic_cell_two(src[6]),
		.capture_unit_one(src[7]), .capture_unit_two(src[8]), .channel_select(chan),
		.ref_pos_select(pref), .ref_neg_select(nref), .converter_powered(pwr),
		.sample_hold(hold), .sar_code(sar), .wake_request(wake));
	acs_far far (.clk(clk), .reset_n(reset_n), .vin(vin), .kick(kick), .compare_high(cmp),
		.rc_tick(rct), .src(src));
	initial begin
		forever #25 clk = ~clk;
	end
	//////////////////////////////////////////////////////////////////////////////
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic cmp_v(input logic [33:0] g, input logic [33:0] e);
		checks_done++;
		if (g !== e) begin
			mismatches++;
			$display("BAD t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic lim(inout int n);
		n++;
		if (n > 4000) begin
			mismatches++;
			summarize();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] e = OK);
		int n;
		n = 0;
		wq.push_back(e);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		do begin
			@(posedge clk);
			lim(n);
			awvalid <= awvalid && !awready;
			wvalid <= wvalid && !wready;
		end while ((awvalid && !awready) || (wvalid && !wready));
		do begin
			@(posedge clk);
			lim(n);
		end while (!bvalid);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] e = OK);
		int n;
		n = 0;
		rq.push_back({e, 24'h0, d});
		araddr <= a;
		arvalid <= 1'h1;
		do begin
			@(posedge clk);
			lim(n);
		end while (!arready);
		arvalid <= 1'h0;
		do begin
			@(posedge clk);
			lim(n);
		end while (!rvalid);
	endtask
	task automatic rise(output int d);
		int n;
		n = 0;
		d = 0;
		while (!hold) begin
			@(posedge clk);
			d++;
			lim(n);
		end
	endtask
	task automatic conv(input logic [7:0] ca, output int d, output int len);
		int n;
		n = 0;
		len = 0;
		wr(CA, ca);
		rise(d);
		while (hold) begin
			@(posedge clk);
			len++;
			lim(n);
		end
	endtask
	function automatic logic [15:0] fmt(input logic [9:0] r, input logic j);
		return j ? {6'h0, r} : {r, 6'h0};
	endfunction
	always @(posedge clk) begin
		if (bvalid && bready) begin
			cmp_v(bresp, wq.pop_front());
		end
		if (rvalid && rready) begin
			cmp_v({rresp, rdata}, rq.pop_front());
		end
	end
	//////////////////////////////////////////////////////////////////////////////
	initial begin
		logic [2:0] cks [6] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6};
		int nd [6] = '{2, 4, 8, 16, 32, 64};
		logic [3:0] tc [9] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hc, 4'hd};
		int d0, d1, l;
		logic v, j;
		logic [5:0] ch;
		logic [2:0] rf;
		logic [15:0] e;
		d0 = $urandom(32'h7668);
		repeat (10) @(posedge clk);
		reset_n <= 1'h1;
		for (int i = 0; i < 6; i++) rd(8'(i * 4), 8'h0);
		rd(8'h18, 8'h0, acs_pkg::RESP_SLVERR);
		wr(8'h18, 8'hff, acs_pkg::RESP_SLVERR);
		wr(CA, 8'h03);
		repeat (4) @(posedge clk);
		rd(CA, 8'h01);
		rd(ST, 8'h04);
		$display("test reset and enable done");
		for (int i = 0; i < 6; i++) begin
			v = 1'($urandom);
			j = 1'($urandom);
			ch = 6'($urandom);
			rf = 3'($urandom);
			vin <= v;
			wr(CB, {j, cks[i], 1'h0, rf});
			wr(CA, {ch, 2'h1});
			repeat (8) @(posedge clk);
			conv({ch, 2'h3}, d0, l);
			cmp_v(l, 12 * nd[i]);
			cmp_v(chan, ch);
			cmp_v({nref, pref}, rf);
			cmp_v(sar, {10{v}});
			e = fmt({10{v}}, j);
			rd(CA, {ch, 2'h1});
			rd(ST, 8'h05);
			rd(RH, e[15:8]);
			rd(RL, e[7:0]);
			wr(ST, 8'h01);
			rd(ST, 8'h04);
		end
		$display("test clock codes done");
		vin <= 1'h0;
		wr(CB, 8'h60);
		wr(CA, 8'h01);
		repeat (8) @(posedge clk);
		wr(CA, 8'h03);
		rise(d1);
		repeat (160) @(posedge clk);
		vin <= 1'h1;
		repeat (130) @(posedge clk);
		wr(CA, 8'h01);
		repeat (4) @(posedge clk);
		e = fmt(10'h1ff, 1'h0);
		rd(RH, e[15:8]);
		rd(RL, e[7:0]);
		rd(CA, 8'h01);
		$display("test abort done");
		wr(CB, 8'h80);
		wr(ST, 8'h01);
		kick <= 9'h1ff;
		@(posedge clk);
		kick <= 9'h0;
		repeat (8) @(posedge clk);
		cmp_v(hold, 1'h0);
		for (int i = 0; i < 9; i++) begin
			wr(acs_pkg::OFS_TRIGGER, {4'h0, tc[i]});
			repeat (8) @(posedge clk);
			kick <= 9'h1 << ((i + 1) % 9);
			@(posedge clk);
			kick <= 9'h0;
			repeat (8) @(posedge clk);
			cmp_v(hold, 1'h0);
			kick <= 9'h1 << i;
			@(posedge clk);
			kick <= 9'h0;
			repeat (8) @(posedge clk);
			cmp_v(hold, 1'h1);
			repeat (30) @(posedge clk);
		end
		$display("test triggers done");
		wr(CB, 8'h60);
		wr(CA, 8'h03);
		rise(d1);
		sleep_mode <= 1'h1;
		repeat (4) @(posedge clk);
		cmp_v({pwr, hold}, 2'h0);
		rd(CA, 8'h01);
		sleep_mode <= 1'h0;
		wr(CB, 8'hb0);
		wr(ST, 8'h03);
		sleep_mode <= 1'h1;
		kick <= 9'h100;
		@(posedge clk);
		kick <= 9'h0;
		repeat (10) @(posedge clk);
		cmp_v(hold, 1'h0);
		conv(8'h03, d1, l);
		cmp_v(d1, d0 + 4);
		cmp_v(wake, 1'h1);
		rd(RH, 8'h03);
		rd(RL, 8'hff);
		wr(ST, 8'h01);
		cmp_v(wake, 1'h0);
		conv(8'h03, d1, l);
		repeat (2) @(posedge clk);
		cmp_v({pwr, wake}, 2'h0);
		rd(CA, 8'h01);
		sleep_mode <= 1'h0;
		$display("test sleep done");
		wr(CB, 8'h60);
		wr(CA, 8'h03);
		rise(d1);
		reset_n <= 1'h0;
		repeat (2) @(posedge clk);
		reset_n <= 1'h1;
		@(posedge clk);
		cmp_v(hold, 1'h0);
		rd(CA, 8'h00);
		rd(CB, 8'h00);
		$display("test reset in flight done");
		summarize();
	end
endmodule // tb
